/* common/vwt_pkg.sv */
/*
 * vwt_pkg: constants and carrier types of the A32 window translator.
 * Assumes a 32-bit processor address and a 32-bit VMEbus A32 address.
 */
// How it works
// - type 0: second window off, settings ignored
// - type 1: target equals start, offset ignored
// - type 2: start, end and offset all used
// - start is upper half, low half zero
// - end is upper half, low half ones
// - type 2 upper half is start+offset mod 2^16
// - primary window hit issues matching A32 cycle
// - primary window always active, no disable
// - second window disabled after reset
// - overlap: second window dropped, primary kept
// - unmapped space goes to local add-on devices
// - discovery base: 256KB region of 8KB slots
// - slave array base: per-board slots by index
// - slave slot size counted in 64KB pages
package vwt_pkg;

    localparam int ADDR_W = 32;
    localparam int HALF_W = 16;
    localparam logic [15:0] LOW_ZERO = 16'h0000;
    localparam logic [15:0] LOW_ONES = 16'hffff;
    localparam int SEG_SHIFT = 18;
    localparam int SLOT_SHIFT = 13;
    localparam int PAGE_SHIFT = 16;
    localparam int BOARD_W = 4;
    localparam int PAGE_CNT_W = 8;

    typedef enum logic [1:0]
    {
        VWT_TYPE_OFF,
        VWT_TYPE_SHARED,
        VWT_TYPE_XLAT,
        VWT_TYPE_RSVD
    } vwt_type_t;

    typedef enum logic [1:0]
    {
        VWT_DST_NONE,
        VWT_DST_VME,
        VWT_DST_ADDON
    } vwt_dst_t;

    typedef struct packed
    {
        logic [15:0] start_hi;
        logic [15:0] end_hi;
    } vwt_range_t;

    typedef struct packed
    {
        vwt_range_t range;
        logic [15:0] offset_hi;
        vwt_type_t wtype;
    } vwt_xlat_cfg_t;

    typedef struct packed
    {
        logic valid;
        logic write;
        logic [31:0] addr;
    } vwt_req_t;

    typedef struct packed
    {
        vwt_dst_t dst;
        logic write;
        logic [31:0] addr;
    } vwt_out_t;

endpackage

/* hw/vwt_range_match.sv */
/*
 * vwt_range_match: tests an address against a 64KB-granular range.
 * Assumes start and end give the upper address halves.
 */
`timescale 1ns/1ps
module vwt_range_match
    import vwt_pkg::*;
(
    input wire logic [31:0] addr_i,
    input wire vwt_range_t range_i,
    output logic hit_o
);
    logic [31:0] lo;
    logic [31:0] hi;

    // ****************************************
    // range bounds
    // ****************************************
    always_comb
    begin
        lo = {range_i.start_hi, LOW_ZERO};
        hi = {range_i.end_hi, LOW_ONES};
        hit_o = (addr_i >= lo) && (addr_i <= hi);
    end
endmodule

/* hw/vwt_translator.sv */
/*
 * vwt_translator: decodes processor cycles into VMEbus A32 cycles through
 * a fixed primary window and a configurable translating window; also
 * places the discovery and slave slots of this board.
 * Assumes configuration held stable by software between cycles.
 */
`timescale 1ns/1ps
module vwt_translator
    import vwt_pkg::*;
#(
    parameter int BOARD_IDX_W = BOARD_W,
    parameter int PAGES_W = PAGE_CNT_W
)
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire vwt_range_t primary_window_i,
    input wire vwt_xlat_cfg_t xlat_window_i,
    input wire logic xlat_cfg_load_i,
    input wire logic [15:0] discovery_segment_base_hi_i,
    input wire logic [15:0] slave_array_base_hi_i,
    input wire logic [PAGES_W-1:0] slave_slot_page_count_i,
    input wire logic [BOARD_IDX_W-1:0] board_idx_i,
    input wire vwt_req_t cpu_req_i,
    output vwt_out_t cycle_o,
    output logic cycle_valid_o,
    output logic xlat_active_o,
    output logic xlat_overlap_o,
    output logic [31:0] discovery_slot_base_o,
    output logic [31:0] slave_slot_base_o,
    output logic [31:0] slave_slot_last_o
);
    // ****************************************
    // parameter check
    // ****************************************
    if (BOARD_IDX_W < 1 || BOARD_IDX_W > 5 || PAGES_W < 1 ||
        PAGES_W > 16)
    begin : g_bad_params
        $error("vwt_translator: unsupported parameter values");
    end

    // ****************************************
    // translating window configuration
    // ****************************************
    vwt_xlat_cfg_t xcfg;
    vwt_xlat_cfg_t next_xcfg;
    logic overlap;
    logic next_overlap;
    logic cfg_clash;
    logic [31:0] p_lo;
    logic [31:0] p_hi;
    logic [31:0] x_lo;
    logic [31:0] x_hi;

    always_comb
    begin
        p_lo = {primary_window_i.start_hi, LOW_ZERO};
        p_hi = {primary_window_i.end_hi, LOW_ONES};
        x_lo = {xlat_window_i.range.start_hi, LOW_ZERO};
        x_hi = {xlat_window_i.range.end_hi, LOW_ONES};
        cfg_clash = (xlat_window_i.wtype != VWT_TYPE_OFF) &&
                    (x_lo <= p_hi) && (p_lo <= x_hi);
        next_xcfg = xcfg;
        next_overlap = overlap;
        if (xlat_cfg_load_i)
        begin
            next_overlap = cfg_clash;
            if (cfg_clash || xlat_window_i.wtype == VWT_TYPE_RSVD)
            begin
                next_xcfg = '0;
            end
            else
            begin
                next_xcfg = xlat_window_i;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            xcfg <= '0;
            overlap <= 1'b0;
        end
        else
        begin
            xcfg <= next_xcfg;
            overlap <= next_overlap;
        end
    end

    // ****************************************
    // address decode
    // ****************************************
    logic prim_hit;
    logic xlat_in;
    logic xlat_hit;

    vwt_range_match u_prim
    (
        .addr_i(cpu_req_i.addr),
        .range_i(primary_window_i),
        .hit_o(prim_hit)
    );

    vwt_range_match u_xlat
    (
        .addr_i(cpu_req_i.addr),
        .range_i(xcfg.range),
        .hit_o(xlat_in)
    );

    vwt_out_t cyc;
    vwt_out_t next_cyc;
    logic cyc_v;
    logic next_cyc_v;
    logic [15:0] vme_hi;

    always_comb
    begin
        xlat_hit = xlat_in && (xcfg.wtype != VWT_TYPE_OFF);
        vme_hi = xcfg.range.start_hi;
        if (xcfg.wtype == VWT_TYPE_XLAT)
        begin
            vme_hi = xcfg.range.start_hi + xcfg.offset_hi;
        end
        next_cyc = '0;
        next_cyc_v = 1'b0;
        if (cpu_req_i.valid)
        begin
            next_cyc_v = 1'b1;
            next_cyc.write = cpu_req_i.write;
            if (prim_hit)
            begin
                next_cyc.dst = VWT_DST_VME;
                next_cyc.addr = cpu_req_i.addr;
            end
            else if (xlat_hit)
            begin
                next_cyc.dst = VWT_DST_VME;
                next_cyc.addr = {vme_hi, LOW_ZERO} +
                    (cpu_req_i.addr - {xcfg.range.start_hi, LOW_ZERO});
            end
            else
            begin
                next_cyc.dst = VWT_DST_ADDON;
                next_cyc.addr = cpu_req_i.addr;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            cyc <= '0;
            cyc_v <= 1'b0;
        end
        else
        begin
            cyc <= next_cyc;
            cyc_v <= next_cyc_v;
        end
    end

    // ****************************************
    // discovery and slave slots
    // ****************************************
    logic [31:0] disc;
    logic [31:0] next_disc;
    logic [31:0] slv;
    logic [31:0] next_slv;
    logic [31:0] slv_last;
    logic [31:0] next_slv_last;
    logic [31:0] slot_bytes;

    always_comb
    begin
        next_disc = {discovery_segment_base_hi_i, LOW_ZERO} +
            (32'({board_idx_i}) << SLOT_SHIFT);
        slot_bytes = 32'({slave_slot_page_count_i}) << PAGE_SHIFT;
        next_slv = {slave_array_base_hi_i, LOW_ZERO} +
            32'(32'({board_idx_i}) * slot_bytes);
        next_slv_last = next_slv + slot_bytes - 32'h0000_0001;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            disc <= '0;
            slv <= '0;
            slv_last <= '0;
        end
        else
        begin
            disc <= next_disc;
            slv <= next_slv;
            slv_last <= next_slv_last;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign cycle_o = cyc;
    assign cycle_valid_o = cyc_v;
    assign xlat_active_o = (xcfg.wtype != VWT_TYPE_OFF);
    assign xlat_overlap_o = overlap;
    assign discovery_slot_base_o = disc;
    assign slave_slot_base_o = slv;
    assign slave_slot_last_o = slv_last;
endmodule

/* bench/vwt_translator_monitor.sv */
/* port checker of the translator
   assumes bind onto vwt_translator */
`timescale 1ns/1ps
module vwt_translator_monitor
    import vwt_pkg::*;
#(
    parameter int BOARD_IDX_W = BOARD_W,
    parameter int PAGES_W = PAGE_CNT_W
)
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire vwt_range_t primary_window_i,
    input wire vwt_xlat_cfg_t xlat_window_i,
    input wire logic xlat_cfg_load_i,
    input wire logic [15:0] discovery_segment_base_hi_i,
    input wire logic [15:0] slave_array_base_hi_i,
    input wire logic [PAGES_W-1:0] slave_slot_page_count_i,
    input wire logic [BOARD_IDX_W-1:0] board_idx_i,
    input wire vwt_req_t cpu_req_i,
    input wire vwt_out_t cycle_o,
    input wire logic cycle_valid_o,
    input wire logic xlat_active_o,
    input wire logic xlat_overlap_o,
    input wire logic [31:0] discovery_slot_base_o,
    input wire logic [31:0] slave_slot_base_o,
    input wire logic [31:0] slave_slot_last_o
);
/****/
// checks
/****/
default clocking @(posedge clk_i); endclocking
default disable iff (!rstn_i);
wire vwt_range_t pw = primary_window_i;
wire vwt_range_t xr = xlat_window_i.range;
wire [15:0] ah = cpu_req_i.addr[31:16];
wire phit = ah >= pw.start_hi && ah <= pw.end_hi;
wire ovl = xr.start_hi <= pw.end_hi && pw.start_hi <= xr.end_hi;
sequence s_req;
    cpu_req_i.valid;
endsequence
sequence s_load;
    xlat_cfg_load_i;
endsequence
a_cycle_pulse:
assert property ($past(rstn_i) |-> cycle_valid_o == $past(cpu_req_i.valid))
else $error("cycle pulse wrong");
a_primary_pass:
assert property (s_req ##0 phit |=> cycle_o.dst == VWT_DST_VME &&
    cycle_o.addr == $past(cpu_req_i.addr)) else $error("primary wrong");
a_unmapped_addon:
assert property (s_req ##0 !phit && !xlat_active_o |=>
    cycle_o.dst == VWT_DST_ADDON) else $error("unmapped not add-on");
a_load_off:
assert property (s_load ##0 xlat_window_i.wtype == VWT_TYPE_OFF |=>
    !xlat_active_o && !xlat_overlap_o) else $error("off load wrong");
a_overlap_drop:
assert property (s_load ##0 ovl && xlat_window_i.wtype inside
    {VWT_TYPE_SHARED, VWT_TYPE_XLAT} |=> !xlat_active_o && xlat_overlap_o)
else $error("overlap kept window");
a_reset_off:
assert property ($rose(rstn_i) |-> !xlat_active_o && !cycle_valid_o)
else $error("not idle after reset");
a_disc_slot:
assert property ($past(rstn_i) |-> discovery_slot_base_o ==
    {$past(discovery_segment_base_hi_i), 16'h0000} +
    32'($past(board_idx_i)) * 32'h0000_2000) else $error("slot base wrong");
a_slave_base:
assert property ($past(rstn_i) |-> slave_slot_base_o ==
    {$past(slave_array_base_hi_i), 16'h0000} +
    32'($past(board_idx_i)) * 32'($past(slave_slot_page_count_i)) *
    32'h0001_0000) else $error("slave base wrong");
a_slave_last:
assert property ($past(rstn_i) |-> slave_slot_last_o == slave_slot_base_o +
    32'($past(slave_slot_page_count_i)) * 32'h0001_0000 - 32'h0000_0001)
else $error("slave last wrong");
endmodule
bind vwt_translator vwt_translator_monitor #(.BOARD_IDX_W(BOARD_IDX_W),
    .PAGES_W(PAGES_W)) u_mon (.*);

/* bench/vwt_vme_slave.sv */
/* far-side slave: counts A32 cycles
   assumes decoded cycles from the translator */
`timescale 1ns/1ps
module vwt_vme_slave
    import vwt_pkg::*;
(
    input wire logic clk_i,
    input wire vwt_out_t cycle_o,
    input wire logic cycle_valid_o,
    output int vme_count_o
);
    int count = 0;
    assign vme_count_o = count;
    always @(posedge clk_i)
    begin
        if (cycle_valid_o && cycle_o.dst == VWT_DST_VME)
        begin
            count <= count + 1;
        end
    end
endmodule

/* bench/vwt_translator_bench.sv */
/* self-checking bench of the translator
   assumes monitor bound, slave model beside */
`timescale 1ns/1ps
module vwt_translator_bench
    import vwt_pkg::*;
;
/****/
// stimulus
/****/
logic clk_i, rstn_i, xlat_cfg_load_i, cycle_valid_o, act;
logic xlat_active_o, xlat_overlap_o;
vwt_range_t primary_window_i;
vwt_xlat_cfg_t xlat_window_i;
logic [15:0] discovery_segment_base_hi_i, slave_array_base_hi_i;
logic [7:0] slave_slot_page_count_i;
logic [3:0] board_idx_i;
vwt_req_t cpu_req_i;
vwt_out_t cycle_o;
logic [31:0] discovery_slot_base_o, slave_slot_base_o, slave_slot_last_o;
logic [31:0] seed = 32'h0001_06E4, r, eb;
int vc, fail_count = 0, n_checks = 0, nvme = 0;
vwt_translator u_dut (.*);
vwt_vme_slave u_vme (.clk_i(clk_i), .cycle_o(cycle_o),
    .cycle_valid_o(cycle_valid_o), .vme_count_o(vc));
initial
begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
end
function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
endfunction
function automatic logic [33:0] dec(logic [31:0] a);
    vwt_xlat_cfg_t c = xlat_window_i;
    logic [15:0] h = a[31:16];
    if (h >= primary_window_i.start_hi && h <= primary_window_i.end_hi)
        return {VWT_DST_VME, a};
    if (act && h >= c.range.start_hi && h <= c.range.end_hi)
        return {VWT_DST_VME, h + (c.wtype == VWT_TYPE_XLAT ?
            c.offset_hi : 16'h0000), a[15:0]};
    return {VWT_DST_ADDON, a};
endfunction
task chk(input logic [33:0] seen, input logic [33:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
        fail_count++;
        $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
endtask
task req(input logic [31:0] a, input logic w);
    logic [33:0] e;
    e = dec(a);
    cpu_req_i = '{1'b1, w, a};
    @(negedge clk_i);
    chk({cycle_valid_o, cycle_o.write, cycle_o.dst}, {1'b1, w, e[33:32]});
    chk(cycle_o.addr, e[31:0]);
    if (e[33:32] == VWT_DST_VME)
    begin
        nvme++;
    end
endtask
task ld(input vwt_type_t t, input logic [15:0] s, e, o);
    logic ov;
    ov = t != VWT_TYPE_OFF && s <= primary_window_i.end_hi &&
        primary_window_i.start_hi <= e;
    xlat_window_i = '{'{s, e}, o, t};
    xlat_cfg_load_i = 1;
    @(negedge clk_i);
    act = (t == VWT_TYPE_SHARED || t == VWT_TYPE_XLAT) && !ov;
    chk({xlat_active_o, xlat_overlap_o}, {act, ov});
endtask
task test_done;
    $display("checks=%0d fails=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
        $display("verification passed");
    else
        $display("verification failed");
    $finish;
endtask
initial
begin
    rstn_i = 0;
    xlat_cfg_load_i = 0;
    cpu_req_i = '0;
    xlat_window_i = '0;
    act = 0;
    primary_window_i = '{16'hE000, 16'hFCAF};
    {discovery_segment_base_hi_i, slave_array_base_hi_i} = 32'hEFFC_F000;
    {slave_slot_page_count_i, board_idx_i} = 12'h010;
    repeat (5) @(negedge clk_i);
    chk({xlat_active_o, cycle_valid_o}, '0);
    rstn_i = 1;
    @(negedge clk_i);
    req(32'hA000_0000, 0);
    req(32'hE000_0000, 1);
    cpu_req_i.valid = 0;
    for (int t = 0; t < 4; t++)
    begin
        ld(vwt_type_t'(t), 16'hA000, 16'hDFFF, 16'h7000);
        xlat_cfg_load_i = 0;
        req(32'hA000_0000, 0);
        req(32'hDFFF_FFFF, 1);
        req(32'h9FFF_FFFF, 0);
        req(32'hA123_4567, 1);
        cpu_req_i.valid = 0;
    end
    ld(VWT_TYPE_SHARED, 16'hE000, 16'hE0FF, 16'h0000);
    ld(VWT_TYPE_XLAT, 16'hF000, 16'hF0FF, 16'h1234);
    xlat_cfg_load_i = 0;
    req(32'hE010_0000, 0);
    cpu_req_i.valid = 0;
    ld(VWT_TYPE_XLAT, 16'hA000, 16'hDFFF, 16'hE000);
    xlat_cfg_load_i = 0;
    repeat (200)
    begin
        r = rnd();
        req(r, r[0]);
    end
    cpu_req_i.valid = 0;
    rstn_i = 0;
    repeat (2) @(negedge clk_i);
    rstn_i = 1;
    act = 0;
    @(negedge clk_i);
    chk({xlat_active_o, xlat_overlap_o, cycle_valid_o}, '0);
    req(32'hA123_4567, 0);
    cpu_req_i.valid = 0;
    repeat (20)
    begin
        {discovery_segment_base_hi_i, slave_array_base_hi_i} = rnd();
        r = rnd();
        {slave_slot_page_count_i, board_idx_i} = r[11:0];
        repeat (2) @(negedge clk_i);
        chk(discovery_slot_base_o, 32'({discovery_segment_base_hi_i,
            16'h0000} + board_idx_i * 32'h0000_2000));
        eb = {slave_array_base_hi_i, 16'h0000} +
            board_idx_i * slave_slot_page_count_i * 32'h0001_0000;
        chk(slave_slot_base_o, eb);
        chk(slave_slot_last_o, 32'(eb + slave_slot_page_count_i *
            32'h0001_0000 - 32'h0000_0001));
    end
    chk(vc, nvme);
    test_done;
end
endmodule
